// ===== src/p4t_cfg.svh
// Register offsets, field positions and reset values of the port 4 tune/status slice
`ifndef P4T_CFG_SVH
`define P4T_CFG_SVH

// ==========================================================
// Register map
`define P4T_ADDR_W           16
`define P4T_DATA_W           8
`define P4T_SQ_TRIM_OFS      16'h70cc
`define P4T_LINK_STAT_OFS    16'h71c0

// ==========================================================
// Field positions
`define P4T_SQ_TRIM_MSB      2
`define P4T_SQ_TRIM_LSB      0
`define P4T_LINK_STATE_MSB   7
`define P4T_LINK_STATE_LSB   4
`define P4T_LINK_RSVD_BIT    3
`define P4T_LINK_SUB_MSB     2
`define P4T_LINK_SUB_LSB     0

// ==========================================================
// Reset values
`define P4T_SQ_TRIM_RST      3'h0
`define P4T_LINK_STATE_RST   4'h0
`define P4T_LINK_SUB_RST     3'h0
`define P4T_RDATA_RST        8'h00
`define P4T_STEPS_RST        4'h0

`endif

// ===== src/p4t_pkg.sv
// Types shared by the port 4 tune/status slice
package p4t_pkg;

   // ==========================================================
   // Link state codes
   typedef enum logic [3:0] {
      P4T_LS_U0         = 4'h0,
      P4T_LS_U1         = 4'h1,
      P4T_LS_U2         = 4'h2,
      P4T_LS_U3         = 4'h3,
      P4T_LS_DISABLED   = 4'h4,
      P4T_LS_RX_DETECT  = 4'h5,
      P4T_LS_INACTIVE   = 4'h6,
      P4T_LS_POLLING    = 4'h7,
      P4T_LS_RECOVERY   = 4'h8,
      P4T_LS_HOT_RESET  = 4'h9,
      P4T_LS_COMPLIANCE = 4'ha,
      P4T_LS_LOOPBACK   = 4'hb
   } p4t_link_state_type;

   // ==========================================================
   // Squelch trim codes
   typedef enum logic [2:0] {
      P4T_SQ_NOMINAL = 3'h0,
      P4T_SQ_DN_1    = 3'h1,
      P4T_SQ_DN_2    = 3'h2,
      P4T_SQ_DN_3    = 3'h3,
      P4T_SQ_DN_4    = 3'h4,
      P4T_SQ_DN_5    = 3'h5,
      P4T_SQ_UP_2    = 3'h6,
      P4T_SQ_UP_1    = 3'h7
   } p4t_sq_code_type;

endpackage

// ===== src/p4t_trim_if.sv
// Carrier between the register bank and the squelch trim decoder
`timescale 1ns/1ps
`default_nettype none

interface p4t_trim_if;
   logic        [2:0] trim_code;
   logic signed [3:0] trim_steps;

   modport ctrl (output trim_code, input trim_steps);
   modport dec  (input trim_code, output trim_steps);
endinterface

`default_nettype wire

// ===== src/p4t_sq_decode.sv
// Squelch trim code to signed trip point step decoder
`timescale 1ns/1ps
`default_nettype none
`include "p4t_cfg.svh"

module p4t_sq_decode
   import p4t_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   p4t_trim_if.dec  tif
);

   // ==========================================================
   // Decode: steps of 12.5 mV, negative lowers the trip point
   function automatic logic signed [3:0] trim_to_steps(input logic [2:0] code);
      logic signed [3:0] s;
      s = 4'sh0;
      case (code)
         P4T_SQ_DN_1: s = -4'sh1;
         P4T_SQ_DN_2: s = -4'sh2;
         P4T_SQ_DN_3: s = -4'sh3;
         P4T_SQ_DN_4: s = -4'sh4;
         P4T_SQ_DN_5: s = -4'sh5;
         P4T_SQ_UP_2: s = 4'sh2;
         P4T_SQ_UP_1: s = 4'sh1;
         default:     s = 4'sh0;
      endcase
      return s;
   endfunction

   logic signed [3:0] steps_nxt;
   logic signed [3:0] steps_r;

   assign steps_nxt = trim_to_steps(tif.trim_code); // RQ2 RQ3

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         steps_r <= `P4T_STEPS_RST;
      end else begin
         steps_r <= steps_nxt;
      end
   end

   assign tif.trim_steps = steps_r;

   // ==========================================================
   // Checks
   chk_lower_step_size: assert property ( // RQ2
      @(posedge sys_clk) disable iff (!resetn)
      (tif.trim_code inside {[3'h1:3'h5]}) |=>
         (steps_r == -$signed({1'b0, $past(tif.trim_code)})))
      else $error("Lowering trim code gave wrong step count");

   chk_raise_steps: assert property ( // RQ3
      @(posedge sys_clk) disable iff (!resetn)
      (tif.trim_code == 3'h6) ##1 (tif.trim_code == 3'h7) |->
         (steps_r == 4'sh2) ##1 (steps_r == 4'sh1))
      else $error("Raising trim codes gave wrong step count");

   chk_nominal_zero: assert property ( // RQ1
      @(posedge sys_clk) disable iff (!resetn)
      (tif.trim_code == 3'h0) |=> (steps_r == 4'sh0))
      else $error("Nominal trim code moved the trip point");

endmodule

`default_nettype wire

// ===== src/p4t_regs.sv
// Port 4 squelch trim and SuperSpeed link status register bank
`timescale 1ns/1ps
`default_nettype none
`include "p4t_cfg.svh"

// How it works
// [RQ1] The trim register keeps a 3-bit squelch trim in bits 2:0 that software writes and reads, code zero meaning the nominal trip point.
// [RQ2] Trim codes one to five lower the trip point by one to five steps of 12.5 mV, giving at most 62.5 mV less.
// [RQ3] Code six raises the trip point by 25 mV and code seven raises it by 12.5 mV.
// [RQ4] Bits 7:3 of the trim register are reserved, read zero and ignore writes, so only the trim bits take a write.
// [RQ5] The link status register is read-only and shows the link state in bits 7:4, zero in bit 3 and the sub-state in bits 2:0.
// [RQ6] The link state code runs from 0 for U0 through 0xB for loopback in the fixed documented order.
// [RQ7] Writes to read-only or reserved bits change nothing, and unmapped or reserved bits read as zero.
module p4t_regs
   import p4t_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   input  wire logic [`P4T_ADDR_W-1:0]  reg_addr,
   input  wire logic [`P4T_DATA_W-1:0]  reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [`P4T_DATA_W-1:0]  reg_rdata,
   input  wire logic [3:0]              link_state_in,
   input  wire logic [2:0]              link_sub_state_in,
   output logic      [2:0]              squelch_threshold_trim,
   output logic signed [3:0]            trip_offset_steps,
   output logic                         link_state_legal
);

   // ==========================================================
   // Address decode
   logic hit_trim;
   logic hit_stat;
   logic trim_we;

   assign hit_trim = (reg_addr == `P4T_SQ_TRIM_OFS);
   assign hit_stat = (reg_addr == `P4T_LINK_STAT_OFS);
   assign trim_we  = reg_wr && hit_trim;

   // ==========================================================
   // Squelch trim register
   logic [2:0] trim_r;
   logic [2:0] trim_nxt;

   // Only bits 2:0 are taken; 7:3 of the write data are dropped
   assign trim_nxt = trim_we ?
      reg_wdata[`P4T_SQ_TRIM_MSB:`P4T_SQ_TRIM_LSB] : trim_r; // RQ1 RQ4

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         trim_r <= `P4T_SQ_TRIM_RST;
      end else begin
         trim_r <= trim_nxt;
      end
   end

   assign squelch_threshold_trim = trim_r;

   // ==========================================================
   // Trim decoder
   p4t_trim_if tif ();

   assign tif.trim_code = trim_r;

   p4t_sq_decode u_sq_decode (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tif     (tif)
   );

   assign trip_offset_steps = tif.trim_steps; // RQ2 RQ3

   // ==========================================================
   // Link status capture
   logic [3:0] lstate_r;
   logic [2:0] lsub_r;
   logic       legal_r;
   logic       legal_nxt;

   function automatic logic state_is_legal(input logic [3:0] code);
      return (code <= P4T_LS_LOOPBACK);
   endfunction

   assign legal_nxt = state_is_legal(link_state_in); // RQ6

   // Hardware is the only writer; bus writes never reach these
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lstate_r <= `P4T_LINK_STATE_RST;
         lsub_r   <= `P4T_LINK_SUB_RST;
         legal_r  <= 1'b1;
      end else begin
         lstate_r <= link_state_in;     // RQ5
         lsub_r   <= link_sub_state_in; // RQ5
         legal_r  <= legal_nxt;
      end
   end

   assign link_state_legal = legal_r;

   // ==========================================================
   // Read data
   logic [7:0] trim_word;
   logic [7:0] stat_word;
   logic [7:0] rd_mux;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   assign trim_word = {5'h00, trim_r};                        // RQ4
   assign stat_word = {lstate_r, 1'b0, lsub_r};               // RQ5 RQ7
   assign rd_mux    = hit_trim ? trim_word :
                      hit_stat ? stat_word : 8'h00;           // RQ7
   assign rdata_nxt = reg_rd ? rd_mux : 8'h00;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= `P4T_RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ==========================================================
   // Checks
   chk_trim_write_read: assert property ( // RQ1
      @(posedge sys_clk) disable iff (!resetn)
      trim_we ##1 (reg_rd && hit_trim && !reg_wr) |=>
         (reg_rdata[2:0] == $past(reg_wdata[2:0], 2)))
      else $error("Trim value read back differs from value written");

   chk_trim_reserved_zero: assert property ( // RQ4
      @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && hit_trim) |=>
         (reg_rdata[7:3] == 5'h00) && (reg_rdata[2:0] == $past(trim_r)))
      else $error("Trim register reserved bits not zero");

   chk_trim_holds: assert property ( // RQ4
      @(posedge sys_clk) disable iff (!resetn)
      !trim_we |=> $stable(squelch_threshold_trim))
      else $error("Trim changed without a write to its offset");

   chk_status_layout: assert property ( // RQ5
      @(posedge sys_clk) disable iff (!resetn)
      ##2 (reg_rd && hit_stat) |=>
         (reg_rdata[7:4] == $past(link_state_in, 2)) &&
         (reg_rdata[2:0] == $past(link_sub_state_in, 2)) &&
         !reg_rdata[3])
      else $error("Link status read does not show captured state");

   chk_state_range: assert property ( // RQ6
      @(posedge sys_clk) disable iff (!resetn)
      ##1 1'b1 |-> (link_state_legal == ($past(link_state_in) <= 4'hb)))
      else $error("Link state legality flag wrong");

   chk_status_ro: assert property ( // RQ7
      @(posedge sys_clk) disable iff (!resetn)
      (reg_wr && hit_stat) |=> $stable(squelch_threshold_trim))
      else $error("Write to status offset disturbed the trim");

   chk_unmapped_zero: assert property ( // RQ7
      @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && !hit_trim && !hit_stat) |=> (reg_rdata == 8'h00))
      else $error("Unmapped read returned nonzero data");

   chk_rdata_one_cycle: assert property ( // RQ7
      @(posedge sys_clk) disable iff (!resetn)
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("Read data present without a read");

endmodule

`default_nettype wire

// ===== dv/p4t_regs_tb_top.sv
// Self-checking testbench of the port 4 squelch trim and link status slice
`timescale 1ns/1ps
`default_nettype none
`include "p4t_cfg.svh"

module p4t_regs_tb_top
   import p4t_pkg::*;
;
   logic              sys_clk;
   logic              resetn;
   logic [15:0]       reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_rdata;
   logic [3:0]        link_state_in;
   logic [2:0]        link_sub_state_in;
   logic [2:0]        sq_trim;
   logic signed [3:0] trip_steps;
   logic              link_legal;
   int                error_cnt;
   int                compares;

   // ==========================================================
   // Device under test
   p4t_regs i_p4t_regs (
      .sys_clk                (sys_clk),
      .resetn                 (resetn),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .link_state_in          (link_state_in),
      .link_sub_state_in      (link_sub_state_in),
      .squelch_threshold_trim (sq_trim),
      .trip_offset_steps      (trip_steps),
      .link_state_legal       (link_legal)
   );

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [15:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= addr;
      reg_wdata <= data;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [15:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= addr;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      data = reg_rdata;
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      check("rdata in reset", reg_rdata, 8'h00);
      check("trim in reset", {5'h00, sq_trim}, 8'h00);
      check("steps in reset", {{4{trip_steps[3]}}, trip_steps}, 8'h00);
      check("legal in reset", {7'h00, link_legal}, 8'h01);
      $display("test_reset done");
   endtask

   task automatic test_trim();
      int         steps_exp [8] = '{0, -1, -2, -3, -4, -5, 2, 1};
      logic [7:0] rd;
      for (int i = 0; i < 8; i++) begin
         wr_reg(`P4T_SQ_TRIM_OFS, {5'h1f, 3'(i)});
         check("trim out", {5'h00, sq_trim}, 8'(i));
         @(posedge sys_clk);
         #1;
         check("trip steps", {{4{trip_steps[3]}}, trip_steps}, 8'(steps_exp[i]));
         rd_reg(`P4T_SQ_TRIM_OFS, rd);
         check("trim read", rd, 8'(i));
      end
      $display("test_trim done");
   endtask

   task automatic test_link();
      logic [7:0] rd;
      for (int s = 0; s < 12; s++) begin
         @(posedge sys_clk);
         link_state_in     <= 4'(s);
         link_sub_state_in <= 3'(s);
         rd_reg(`P4T_LINK_STAT_OFS, rd);
         check("link status", rd, {4'(s), 1'b0, 3'(s)});
         check("legal", {7'h00, link_legal}, 8'h01);
      end
      @(posedge sys_clk);
      link_state_in <= 4'hc;
      @(posedge sys_clk);
      #1;
      check("legal above range", {7'h00, link_legal}, 8'h00);
      $display("test_link done");
   endtask

   task automatic test_ro();
      logic [7:0] rd;
      @(posedge sys_clk);
      link_state_in     <= 4'h8;
      link_sub_state_in <= 3'h5;
      wr_reg(`P4T_SQ_TRIM_OFS, 8'h03);
      wr_reg(`P4T_LINK_STAT_OFS, 8'hff);
      wr_reg(16'h70cd, 8'h06);
      wr_reg(16'h0000, 8'h05);
      check("trim after foreign writes", {5'h00, sq_trim}, 8'h03);
      rd_reg(`P4T_LINK_STAT_OFS, rd);
      check("status after write", rd, 8'h85);
      rd_reg(16'h70cd, rd);
      check("unmapped read", rd, 8'h00);
      rd_reg(`P4T_SQ_TRIM_OFS, rd);
      check("trim read", rd, 8'h03);
      @(posedge sys_clk);
      #1;
      check("rdata idle", reg_rdata, 8'h00);
      $display("test_ro done");
   endtask

   // Write, read and read again with no idle cycle between the strobes
   task automatic test_b2b();
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= `P4T_SQ_TRIM_OFS;
      reg_wdata <= 8'hfd;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge sys_clk);
      reg_addr  <= `P4T_LINK_STAT_OFS;
      #1;
      check("b2b trim read", reg_rdata, 8'h05);
      @(posedge sys_clk);
      reg_rd    <= 1'b0;
      #1;
      check("b2b status read", reg_rdata, 8'h85);
      @(posedge sys_clk);
      #1;
      check("rdata after reads", reg_rdata, 8'h00);
      check("b2b trim out", {5'h00, sq_trim}, 8'h05);
      $display("test_b2b done");
   endtask

   // ==========================================================
   // Clock, reset, sequence and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      resetn            = 1'b0;
      reg_addr          = 16'h0000;
      reg_wdata         = 8'h00;
      reg_wr            = 1'b0;
      reg_rd            = 1'b0;
      link_state_in     = 4'h0;
      link_sub_state_in = 3'h0;
      error_cnt         = 0;
      compares          = 0;
      repeat (20) @(posedge sys_clk);
      #1;
      test_reset();
      @(posedge sys_clk);
      resetn <= 1'b1;
      test_trim();
      test_link();
      test_ro();
      test_b2b();
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      $display("watchdog expired");
      finish_test();
   end
endmodule

`default_nettype wire
